/* File: hw/mff_top.sv */
/*
 * Four or two independent FIFOs with flag decoding, bus matching and
 * echo outputs, all on one clock.
 * Assumes the host drives strobes on CLOCK_I and holds straps steady
 * for at least four cycles of RESET_I.
 */

//
// Contract
// - four-FIFO mode gives four FIFOs, 10-bit buses, own strobes each.
// - two-FIFO mode gives two FIFOs, widths 10 or 20 bits.
// - each FIFO has own read, write, output enable and four flags.
// - each FIFO drives its own echo read clock and echo read enable.
// - standard flags: empty low at 0, almost-empty low up to n.
// - standard: almost-full low from depth-m, full low at depth.
// - fall-through: output-ready high at 0, almost-empty low to n+1.
// - fall-through: almost-full low from depth+1-m, input-ready high at depth+1.
// - empty and full offsets are held separately per FIFO.
// - width selects are latched during reset; host keeps them stable.
// - the chosen widths apply to both FIFOs alike.
// - 10-bit ports give 32,768 locations per FIFO.
// - 20-bit ports give half as many 20-bit locations.
// - storage per FIFO is fixed whatever width is chosen.
// - double rate words take two pieces, halving usable depth.
// - in two-FIFO mode FIFOs 1 and 3 are unused.
// - n is the empty offset; almost-empty low at or below it.
// - m is the full offset, counted back from the full depth.
// - fall-through select during reset picks the timing mode.
// - 20-bit input: bits 19..0 feed FIFO 0, 39..20 FIFO 2.
module mff_top
	import mff_pkg::*;
(
	input  wire logic                      CLOCK_I,
	input  wire logic                      RESET_I,
	input  wire logic                      ORGANISATION_SELECT_I,
	input  wire logic                      FALL_THROUGH_SELECT_SERIAL_IN_I,
	input  wire logic                      INPUT_WIDTH_SELECT_I,
	input  wire logic                      OUTPUT_WIDTH_SELECT_I,
	input  wire logic                      WRITE_DOUBLE_RATE_SELECT_I,
	input  wire logic                      READ_DOUBLE_RATE_SELECT_I,
	input  wire logic [NUM_FIFO-1:0]       WRITE_EN_I,
	input  wire logic [NUM_FIFO-1:0]       READ_EN_I,
	input  wire logic [NUM_FIFO-1:0]       OUTPUT_ENABLE_N_I,
	input  wire logic [NUM_FIFO*LANE_W-1:0] DATA_I,
	input  wire logic [NUM_FIFO*OFF_W-1:0] EMPTY_OFFSET_I,
	input  wire logic [NUM_FIFO*OFF_W-1:0] FULL_OFFSET_I,
	output wire logic [NUM_FIFO*LANE_W-1:0] DATA_O,
	output wire logic [NUM_FIFO-1:0]       DATA_OE_O,
	output wire logic [NUM_FIFO-1:0]       EMPTY_FLAG_N_O,
	output wire logic [NUM_FIFO-1:0]       FULL_FLAG_N_O,
	output wire logic [NUM_FIFO-1:0]       ALMOST_EMPTY_FLAG_N_O,
	output wire logic [NUM_FIFO-1:0]       ALMOST_FULL_FLAG_N_O,
	output wire logic [NUM_FIFO-1:0]       ECHO_READ_CLOCK_O,
	output wire logic [NUM_FIFO-1:0]       ECHO_READ_ENABLE_O
);

	// ********************************************************
	// strap capture
	// ********************************************************
	logic [STRAP_W-1:0] strap_s1;
	logic [STRAP_W-1:0] strap_s2;
	logic [STRAP_W-1:0] strap_s3;
	logic [STRAP_W-1:0] cfg;
	wire  [STRAP_W-1:0] strap_pins;

	assign strap_pins = {READ_DOUBLE_RATE_SELECT_I,
		WRITE_DOUBLE_RATE_SELECT_I,
		OUTPUT_WIDTH_SELECT_I,
		INPUT_WIDTH_SELECT_I,
		FALL_THROUGH_SELECT_SERIAL_IN_I,
		ORGANISATION_SELECT_I};

	// straps are pins: three stages, taken only while the last two stages agree
	always_ff @(posedge CLOCK_I) begin
		strap_s1 <= strap_pins;
		strap_s2 <= strap_s1;
		strap_s3 <= strap_s2;
	end

	// latched only under reset, frozen until the next one
	always_ff @(posedge CLOCK_I) begin
		if (RESET_I && (strap_s2 == strap_s3)) begin
			cfg <= strap_s3;
		end
	end

	// ********************************************************
	// derived organisation
	// ********************************************************
	wire       cfg_quad;
	wire       cfg_fwft;
	wire       iw20;
	wire       ow20;
	wire       ddr;
	wire [1:0] shift;

	// widths are forced to x10 in four-FIFO mode
	assign cfg_quad = cfg[STRAP_QUAD];
	assign cfg_fwft = cfg[STRAP_FALL];
	assign iw20     = ~cfg_quad & cfg[STRAP_IW];
	assign ow20     = ~cfg_quad & cfg[STRAP_OW];
	assign ddr      = cfg[STRAP_WRITE_DOUBLE_RATE_SELECT] | cfg[STRAP_READ_DOUBLE_RATE_SELECT];
	// 10-bit units per word, as a shift: wider output or double rate halves depth
	assign shift    = {1'b0, ow20} + {1'b0, ddr};

	// cross-FIFO taps for the read lanes
	wire [WORD_W-1:0]   rd_word [NUM_FIFO];
	wire [NUM_FIFO-1:0] land;
	wire [NUM_FIFO-1:0] land_half;

	// ********************************************************
	// per FIFO control
	// ********************************************************
	generate
		for (genvar k = 0; k < NUM_FIFO; k++) begin : g_fifo
			// upper 10 bits of a wide write come from the next lane
			localparam int UP = (k % 2 == 0) ? k + 1 : k;
			localparam logic ODD = (k % 2 == 1);

			logic [CNT_W-1:0]  fill;
			logic [CNT_W-1:0]  next_fill;
			logic [CNT_W-1:0]  wunits;
			logic [CNT_W-1:0]  runits;
			logic [CNT_W-1:0]  mem_words;
			logic [CNT_W-1:0]  words;
			logic [CNT_W-1:0]  depth_words;
			logic [CNT_W-1:0]  n_off;
			logic [CNT_W-1:0]  m_off;
			logic [PTR_W-1:0]  wptr;
			logic [PTR_W-1:0]  rptr;
			logic              pend;
			logic              out_valid;
			logic              half_q;
			logic              active;
			logic              wr_take;
			logic              rd_take;
			logic              rd_issue;
			logic [WORD_W-1:0] wdata;
			logic [1:0]        half_we;
			mff_flags_type     flags;
			mff_flags_type     flag_q;
			logic              echo_en;
			logic              echo_clk;

			// odd FIFOs sleep in two-FIFO mode
			assign active = cfg_quad | ~ODD;
			assign wunits = iw20 ? CNT_TWO : CNT_ONE;
			assign runits = ow20 ? CNT_TWO : CNT_ONE;

			// a write needs room for all its units
			assign wr_take = active & WRITE_EN_I[k]
				& ((UNIT_DEPTH - fill) >= wunits);
			// fall-through hands out the word already standing at the port
			assign rd_take = READ_EN_I[k] & out_valid;
			// read ignored while empty; prefetch keeps the port filled
			assign rd_issue = active & (fill >= runits)
				& (cfg_fwft ? (~pend & (~out_valid | rd_take))
					: READ_EN_I[k]);

			assign next_fill = fill
				+ (wr_take ? wunits : CNT_ZERO)
				- (rd_issue ? runits : CNT_ZERO);

			// wide input: low lane then the lane above it
			assign wdata = iw20
				? {DATA_I[UP*LANE_W +: LANE_W], DATA_I[k*LANE_W +: LANE_W]}
				: {DATA_I[k*LANE_W +: LANE_W], DATA_I[k*LANE_W +: LANE_W]};
			assign half_we = ~wr_take ? 2'h0
				: iw20 ? 2'h3
				: (wptr[0] ? 2'h2 : 2'h1);

			// levels in output-width words
			assign mem_words   = fill >> shift;
			assign words       = cfg_fwft
				? mem_words + {16'h0000, pend} + {16'h0000, out_valid}
				: mem_words;
			assign depth_words = UNIT_DEPTH >> shift;
			assign n_off = {1'b0, EMPTY_OFFSET_I[k*OFF_W +: OFF_W]};
			assign m_off = {1'b0, FULL_OFFSET_I[k*OFF_W +: OFF_W]};
			assign flags = mff_flag_decode(cfg_fwft, words, depth_words,
				n_off, m_off);

			// pointers, level and the one-word output stage
			always_ff @(posedge CLOCK_I) begin
				if (RESET_I) begin
					fill      <= CNT_ZERO;
					wptr      <= '0;
					rptr      <= '0;
					pend      <= 1'b0;
					out_valid <= 1'b0;
					half_q    <= 1'b0;
				end else begin
					fill <= next_fill;
					if (wr_take) begin
						wptr <= wptr + wunits[PTR_W-1:0];
					end
					if (rd_issue) begin
						rptr <= rptr + runits[PTR_W-1:0];
					end
					pend      <= rd_issue;
					half_q    <= rptr[0];
					out_valid <= cfg_fwft & (pend | (out_valid & ~rd_take));
				end
			end

			// flags registered; idle FIFOs hold their reset pattern
			always_ff @(posedge CLOCK_I) begin
				if (RESET_I || !active) begin
					flag_q <= cfg_fwft ? FLAG_RST_FT : FLAG_RST_STD;
				end else begin
					flag_q <= flags;
				end
			end

			// echoes mark each word landing on the output lanes
			always_ff @(posedge CLOCK_I) begin
				if (RESET_I) begin
					echo_en  <= 1'b0;
					echo_clk <= 1'b0;
				end else begin
					echo_en  <= pend;
					echo_clk <= echo_clk ^ pend;
				end
			end

			mff_mem u_mem (
				.clk_i   (CLOCK_I),
				.we_i    (half_we),
				.waddr_i (wptr[PTR_W-1:1]),
				.wdata_i (wdata),
				.re_i    (rd_issue),
				.raddr_i (rptr[PTR_W-1:1]),
				.rdata_o (rd_word[k])
			);

			assign land[k]      = pend;
			assign land_half[k] = half_q;

			assign EMPTY_FLAG_N_O[k]        = flag_q[3];
			assign FULL_FLAG_N_O[k]         = flag_q[2];
			assign ALMOST_EMPTY_FLAG_N_O[k] = flag_q[1];
			assign ALMOST_FULL_FLAG_N_O[k]  = flag_q[0];
			assign ECHO_READ_ENABLE_O[k]    = echo_en;
			assign ECHO_READ_CLOCK_O[k]     = echo_clk;
		end
	endgenerate

	// ********************************************************
	// output lanes
	// ********************************************************
	generate
		for (genvar l = 0; l < NUM_FIFO; l++) begin : g_lane
			localparam logic ODD = (l % 2 == 1);
			localparam int   LOW = (l % 2 == 1) ? l - 1 : l;

			logic [LANE_W-1:0] lane_q;
			logic [LANE_W-1:0] next_lane;
			logic              lane_oe;
			wire               borrow;
			wire               used;
			wire               load;
			wire               oe_n;

			// odd lanes carry the upper half of a wide even FIFO
			assign borrow = ODD & ~cfg_quad & ow20;
			assign used   = cfg_quad | ~ODD | ow20;
			assign load   = borrow ? land[LOW] : land[l];
			assign oe_n   = borrow ? OUTPUT_ENABLE_N_I[LOW]
				: OUTPUT_ENABLE_N_I[l];

			// narrow output picks the half the read pointer pointed at
			assign next_lane = borrow ? rd_word[LOW][WORD_W-1:LANE_W]
				: (~ow20 & land_half[l]) ? rd_word[l][WORD_W-1:LANE_W]
				: rd_word[l][LANE_W-1:0];

			// output register clears under reset
			always_ff @(posedge CLOCK_I) begin
				if (RESET_I) begin
					lane_q <= '0;
				end else if (load) begin
					lane_q <= next_lane;
				end
			end

			// enable tracks its FIFO's control; unused lanes stay off
			always_ff @(posedge CLOCK_I) begin
				if (RESET_I) begin
					lane_oe <= 1'b0;
				end else begin
					lane_oe <= ~oe_n & used;
				end
			end

			assign DATA_O[l*LANE_W +: LANE_W] = lane_q;
			assign DATA_OE_O[l]                = lane_oe;
		end
	endgenerate

endmodule : mff_top

/* File: hw/mff_pkg.sv */
/*
 * Shared constants, types and the flag decoder for the multi-FIFO block.
 * Assumes one 125 MHz clock and 10-bit storage units per FIFO.
 */
package mff_pkg;

	// ********************************************************
	// organisation and storage
	// ********************************************************
	localparam int NUM_FIFO  = 4;
	localparam int LANE_W    = 10;
	localparam int WORD_W    = 20;
	localparam int MEM_AW    = 14;
	localparam int PTR_W     = 15;
	localparam int CNT_W     = 17;
	localparam int OFF_W     = 16;
	// 10-bit locations per FIFO, 327,680 bits in each FIFO
	localparam logic [CNT_W-1:0] UNIT_DEPTH = 17'h08000;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 17'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE    = 17'h00001;
	localparam logic [CNT_W-1:0] CNT_TWO    = 17'h00002;

	// ********************************************************
	// strap vector bit positions
	// ********************************************************
	localparam int STRAP_W    = 6;
	localparam int STRAP_QUAD = 0;
	localparam int STRAP_FALL = 1;
	localparam int STRAP_IW   = 2;
	localparam int STRAP_OW   = 3;
	localparam int STRAP_WRITE_DOUBLE_RATE_SELECT = 4;
	localparam int STRAP_READ_DOUBLE_RATE_SELECT = 5;

	// ********************************************************
	// flag vector: {empty/ready, full/ready, almost empty, almost full}
	// ********************************************************
	typedef logic [3:0] mff_flags_type;
	localparam mff_flags_type FLAG_RST_STD = 4'h5;
	localparam mff_flags_type FLAG_RST_FT  = 4'h9;

	// level to flag mapping, both timing modes, all active low
	function automatic mff_flags_type mff_flag_decode(
		input logic             fwft,
		input logic [CNT_W-1:0] words,
		input logic [CNT_W-1:0] depth,
		input logic [CNT_W-1:0] n_off,
		input logic [CNT_W-1:0] m_off);
		mff_flags_type f;
		f = FLAG_RST_STD;
		if (fwft) begin
			f[3] = (words == CNT_ZERO);
			f[2] = (words == depth + CNT_ONE);
			f[1] = (words > n_off + CNT_ONE);
			f[0] = (words < depth + CNT_ONE - m_off);
		end else begin
			f[3] = (words != CNT_ZERO);
			f[2] = (words != depth);
			f[1] = (words > n_off);
			f[0] = (words < depth - m_off);
		end
		return f;
	endfunction : mff_flag_decode

endpackage : mff_pkg

/* File: hw/mff_mem.sv */
/*
 * Storage of one FIFO: 20-bit words, each half writable on its own.
 * Assumes one clock; read data leave through a register.
 */
module mff_mem
	import mff_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [1:0]        we_i,
	input  wire logic [MEM_AW-1:0] waddr_i,
	input  wire logic [WORD_W-1:0] wdata_i,
	input  wire logic              re_i,
	input  wire logic [MEM_AW-1:0] raddr_i,
	output logic      [WORD_W-1:0] rdata_o
);

	logic [WORD_W-1:0] mem [0:(1<<MEM_AW)-1];

	// half enables let 10-bit writes fill a 20-bit row in two steps
	always_ff @(posedge clk_i) begin
		if (we_i[0]) begin
			mem[waddr_i][LANE_W-1:0] <= wdata_i[LANE_W-1:0];
		end
		if (we_i[1]) begin
			mem[waddr_i][WORD_W-1:LANE_W] <= wdata_i[WORD_W-1:LANE_W];
		end
		if (re_i) begin
			rdata_o <= mem[raddr_i];
		end
	end

endmodule : mff_mem

/* File: sim/mff_top_monitor.sv */
/* checker on the ports of mff_top.
 * assumes straps and offsets move only while RESET_I is high */
module mff_top_monitor
	import mff_pkg::*;
(
	input wire logic                CLOCK_I,
	input wire logic                RESET_I,
	input wire logic                ORGANISATION_SELECT_I,
	input wire logic                FALL_THROUGH_SELECT_SERIAL_IN_I,
	input wire logic                OUTPUT_WIDTH_SELECT_I,
	input wire logic [NUM_FIFO-1:0] WRITE_EN_I,
	input wire logic [NUM_FIFO-1:0] READ_EN_I,
	input wire logic [NUM_FIFO-1:0] OUTPUT_ENABLE_N_I,
	input wire logic [NUM_FIFO-1:0] DATA_OE_O,
	input wire logic [NUM_FIFO-1:0] EMPTY_FLAG_N_O,
	input wire logic [NUM_FIFO-1:0] FULL_FLAG_N_O,
	input wire logic [NUM_FIFO-1:0] ALMOST_EMPTY_FLAG_N_O,
	input wire logic [NUM_FIFO-1:0] ALMOST_FULL_FLAG_N_O,
	input wire logic [NUM_FIFO-1:0] ECHO_READ_CLOCK_O,
	input wire logic [NUM_FIFO-1:0] ECHO_READ_ENABLE_O
);
	// ****************
	// helpers
	// ****************
	logic [1:0] since;
	logic [2:0] busy;
	wire        live = (since == 2'h3);
	wire        ft   = FALL_THROUGH_SELECT_SERIAL_IN_I;
	// outputs lag release by two edges, so wait three before judging
	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) since <= 2'h0;
		else if (!live) since <= since + 2'h1;
		busy <= {busy[1:0], WRITE_EN_I[0] | READ_EN_I[0]};
	end
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RESET_I);
	// ****************
	// properties
	// ****************
	a_echo_toggle: assert property (live |->
		(ECHO_READ_CLOCK_O ^ $past(ECHO_READ_CLOCK_O)) == ECHO_READ_ENABLE_O)
		else $error("echo clock and echo enable disagree");
	a_read_cause: assert property (live && !ft && ECHO_READ_ENABLE_O[0] |->
		$past(READ_EN_I[0], 2)) else $error("word out without read");
	a_oe_follow: assert property (live |->
		DATA_OE_O[0] == !$past(OUTPUT_ENABLE_N_I[0])) else $error("output enable wrong");
	a_full_almost: assert property (live && (ft ? FULL_FLAG_N_O[0] : !FULL_FLAG_N_O[0])
		|-> !ALMOST_FULL_FLAG_N_O[0]) else $error("full without almost full");
	a_empty_almost: assert property (live && (ft ? EMPTY_FLAG_N_O[0] : !EMPTY_FLAG_N_O[0])
		|-> !ALMOST_EMPTY_FLAG_N_O[0]) else $error("empty without almost empty");
	a_flags_hold: assert property (live && busy == 3'h0 |-> $stable({EMPTY_FLAG_N_O[0],
		FULL_FLAG_N_O[0], ALMOST_EMPTY_FLAG_N_O[0], ALMOST_FULL_FLAG_N_O[0]}))
		else $error("flags moved with no strobe");
	a_unused_fifo: assert property (live && !ORGANISATION_SELECT_I |->
		ECHO_READ_ENABLE_O[1] == 1'b0 && ECHO_READ_ENABLE_O[3] == 1'b0 &&
		!ALMOST_EMPTY_FLAG_N_O[1] && ALMOST_FULL_FLAG_N_O[3]) else $error("unused fifo active");
	a_odd_lanes: assert property (live && !ORGANISATION_SELECT_I && !OUTPUT_WIDTH_SELECT_I
		|-> DATA_OE_O[1] == 1'b0 && DATA_OE_O[3] == 1'b0) else $error("odd lane driven");
endmodule : mff_top_monitor

bind mff_top mff_top_monitor i_mff_top_monitor (.CLOCK_I, .RESET_I, .ORGANISATION_SELECT_I,
	.FALL_THROUGH_SELECT_SERIAL_IN_I, .OUTPUT_WIDTH_SELECT_I, .WRITE_EN_I, .READ_EN_I,
	.OUTPUT_ENABLE_N_I, .DATA_OE_O, .EMPTY_FLAG_N_O, .FULL_FLAG_N_O, .ALMOST_EMPTY_FLAG_N_O,
	.ALMOST_FULL_FLAG_N_O, .ECHO_READ_CLOCK_O, .ECHO_READ_ENABLE_O);

/* File: sim/mff_host.sv */
/* host-side strobe logic for the write and read ports.
 * assumes the clock of mff_top; straps and offsets come from the bench */
module mff_host
	import mff_pkg::*;
(
	input  wire logic                       clk_i,
	output logic      [NUM_FIFO-1:0]        wen_o,
	output logic      [NUM_FIFO-1:0]        ren_o,
	output logic      [NUM_FIFO*LANE_W-1:0] data_o
);
	// ****************
	// strobes
	// ****************
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wen_o = '0;
		ren_o = '0;
		data_o = '0;
	end
	// back-to-back writes, own strobe per fifo
	task automatic put(input logic [3:0] mask, input int cnt, input logic [39:0] base);
		for (int i = 0; i < cnt; i++) begin
			@(posedge clk_i);
			wen_o <= mask;
			data_o <= base + 40'(i);
		end
		@(posedge clk_i);
		wen_o <= '0;
		data_o <= ~data_o; // no stale word once released
	endtask : put
	// one read strobe, taken at the releasing edge
	task automatic get(input logic [3:0] mask);
		@(posedge clk_i);
		ren_o <= mask;
		@(posedge clk_i);
		ren_o <= '0;
	endtask : get
endmodule : mff_host

/* File: sim/test_multi_fifo_flags_bus_matching.sv */
/* self-checking bench for mff_top: levels, fill, bus matching.
 * assumes mff_host drives strobes and data; the bench owns straps */
module test_multi_fifo_flags_bus_matching
	import mff_pkg::*;
;
	// ****************
	// harness
	// ****************
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, org, ft, iw, ow, write_double_rate_select, read_double_rate_select;
	logic [63:0] eoff, foff;
	logic [3:0]  oe_n, wen, ren;
	logic [39:0] din;
	wire  [39:0] dout;
	wire  [3:0]  doe, ef, ff, ae, af, erc, ere;
	int          mismatches = 0;
	int          check_count = 0;
	mff_host i_mff_host (.clk_i(clk), .wen_o(wen), .ren_o(ren), .data_o(din));
	mff_top i_mff_top (.CLOCK_I(clk), .RESET_I(rst), .ORGANISATION_SELECT_I(org),
		.FALL_THROUGH_SELECT_SERIAL_IN_I(ft), .INPUT_WIDTH_SELECT_I(iw),
		.OUTPUT_WIDTH_SELECT_I(ow), .WRITE_DOUBLE_RATE_SELECT_I(write_double_rate_select),
		.READ_DOUBLE_RATE_SELECT_I(read_double_rate_select), .WRITE_EN_I(wen), .READ_EN_I(ren),
		.OUTPUT_ENABLE_N_I(oe_n), .DATA_I(din), .EMPTY_OFFSET_I(eoff), .FULL_OFFSET_I(foff),
		.DATA_O(dout), .DATA_OE_O(doe), .EMPTY_FLAG_N_O(ef), .FULL_FLAG_N_O(ff),
		.ALMOST_EMPTY_FLAG_N_O(ae), .ALMOST_FULL_FLAG_N_O(af), .ECHO_READ_CLOCK_O(erc),
		.ECHO_READ_ENABLE_O(ere));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t %s: %h not %h", $time, what, seen, exp);
		end
	endtask : check
	function automatic logic [3:0] fl(input int k);
		return {ef[k], ff[k], ae[k], af[k]};
	endfunction : fl
	// expected {empty, full, almost empty, almost full}, all active low
	function automatic logic [3:0] xfl(input logic f, input int w, input int d, input int n,
		input int m);
		if (f) begin
			return {w == 0, w == d + 1, w > n + 1, w < d + 1 - m};
		end
		return {w != 0, w != d, w > n, w < d - m};
	endfunction : xfl
	task automatic edges(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : edges
	// straps move only inside reset, held steady throughout
	task automatic boot(input logic [5:0] s, input logic [63:0] e, input logic [63:0] f);
		@(posedge clk);
		rst <= 1'b1;
		{org, ft, iw, ow, write_double_rate_select, read_double_rate_select} <= s;
		eoff <= e;
		foff <= f;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask : boot
	// ****************
	// scenarios
	// ****************
	task automatic t_levels();
		int nn[4] = '{3, 5, 0, 1};
		int mm[4] = '{4, 2, 0, 0};
		boot(6'h20, {16'd1, 16'd0, 16'd5, 16'd3}, {16'd0, 16'd0, 16'd2, 16'd4});
		for (int w = 0; w < 7; w++) begin
			if (w > 0) i_mff_host.put(4'hF, 1, 40'(w));
			edges(4);
			for (int k = 0; k < 4; k++) check(40'(fl(k)), 40'(xfl(0, w, 32768, nn[k], mm[k])), "level");
		end
		for (int w = 1; w < 7; w++) begin
			i_mff_host.get(4'h1);
			edges(1);
			check(40'({ere[0], doe[0], dout[9:0]}), 40'({2'h3, 10'(w)}), "read");
		end
		// each lane's enable follows its own control one edge later
		@(posedge clk);
		oe_n <= 4'h1;
		edges(2);
		check(40'(doe), 40'hE, "output enable");
		@(posedge clk);
		oe_n <= 4'h0;
		edges(2);
	endtask : t_levels
	// step through every threshold, then overfill and take one word back
	// ppw: strobes per output word (two pieces per word at double rate)
	task automatic t_fill(input logic f, input int d, input int n, input int m, input int ppw);
		int cn[11] = '{1, n, n + 1, n + 2, d - m - 1, d - m, d + 1 - m, d - 1, d, d + 1, d + 2};
		int done = 0;
		int cap = f ? d + 1 : d;
		foreach (cn[i]) begin
			i_mff_host.put(4'h1, ppw * (cn[i] - done), 40'h5 + 40'(done));
			done = cn[i];
			edges(4);
			check(40'(fl(0)), 40'(xfl(f, done < cap ? done : cap, d, n, m)), "fill");
			if (f && i == 0) check(40'(dout[19:0]), 40'h5, "fall through");
		end
		i_mff_host.get(4'h1);
		edges(4);
		check(40'(fl(0)), 40'(xfl(f, cap - 1, d, n, m)), "one out");
	endtask : t_fill
	// one x20 word into fifos 0 and 2, read back as two x10 halves
	task automatic t_match();
		boot(6'h08, 64'd1, 64'd3);
		i_mff_host.put(4'hF, 1, {20'h12345, 20'hABCDE});
		edges(4);
		check(40'(fl(0)), 40'(xfl(0, 2, 32768, 1, 3)), "units");
		check(40'(fl(1)), 40'(FLAG_RST_STD), "idle fifo");
		i_mff_host.get(4'h5);
		edges(2);
		check(40'({dout[29:20], dout[9:0]}), 40'({10'h345, 10'h0DE}), "low half");
		i_mff_host.get(4'h5);
		edges(2);
		check(40'({dout[29:20], dout[9:0]}), 40'({10'h048, 10'h2AF}), "high half");
		check(40'({doe[3], doe[1]}), 40'h0, "odd lanes");
	endtask : t_match
	initial begin
		rst = 1'b1;
		{org, ft, iw, ow, write_double_rate_select, read_double_rate_select} = 6'h20;
		eoff = '0;
		foff = '0;
		oe_n = '0;
		t_levels();
		boot(6'h22, 64'd2, 64'd3);
		t_fill(1'b0, 16384, 2, 3, 2);
		boot(6'h1C, 64'd2, 64'd3);
		t_fill(1'b1, 16384, 2, 3, 1);
		t_match();
		report_and_stop();
	end
	// the fills need about 50k cycles; this leaves ample margin
	initial begin
		#700000;
		mismatches++;
		report_and_stop();
	end
endmodule : test_multi_fifo_flags_bus_matching
